// file: verilog/fst_pkg.sv
// Constants and types for the frame-sync trigger block.
// Assumes a single 50 MHz system clock; every count below is in cycles of it.
`default_nettype none

package fst_pkg;

  // ************************************************************
  // Clock
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;

  // ************************************************************
  // Frame periods, primary mode
  // ************************************************************
  localparam real PERIOD_120_MS = 8.3;
  localparam real PERIOD_30_MS = 33.3;
  localparam real PERIOD_15_MS = 66.7;
  localparam int unsigned PERIOD_120_CYC = int'($floor(PERIOD_120_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned PERIOD_30_CYC = int'($floor(PERIOD_30_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned PERIOD_15_CYC = int'($floor(PERIOD_15_MS * 1.0e6 / CLK_PERIOD_NS));

  // ************************************************************
  // Accepted input period window, secondary mode
  // ************************************************************
  localparam real SEC_MIN_MS = 8.33;
  localparam real SEC_MAX_MS = 66.67;
  // Least time rounds up, longest rounds down
  localparam int unsigned SEC_MIN_CYC = int'($ceil(SEC_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned SEC_MAX_CYC = int'($floor(SEC_MAX_MS * 1.0e6 / CLK_PERIOD_NS));

  // ************************************************************
  // Output pulse width
  // ************************************************************
  localparam int unsigned PW_MIN_NS = 37;
  localparam real PW_EXTRA_US = 25.5;
  localparam int unsigned PW_STEP_NS = 100;
  localparam int unsigned PW_W = 11;
  localparam int unsigned PW_MIN_CYC = (PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PW_MAX_CYC =
    int'($floor((PW_MIN_NS + PW_EXTRA_US * 1000.0) / CLK_PERIOD_NS));
  localparam int unsigned PW_STEP_CYC = PW_STEP_NS / CLK_PERIOD_NS;
  typedef logic [PW_W-1:0] fst_pw_t;

  // ************************************************************
  // Frame counter
  // ************************************************************
  localparam int unsigned CNT_W = 22;
  typedef logic [CNT_W-1:0] fst_cnt_t;
  localparam fst_cnt_t CNT_RESET = 22'h000000;

  // ************************************************************
  // Frame-rate select codes
  // ************************************************************
  typedef enum logic [1:0] {
    RATE_30 = 2'h0,
    RATE_120 = 2'h1,
    RATE_15 = 2'h2,
    RATE_RSVD = 2'h3
  } fst_rate_t;

  // ************************************************************
  // Frame-timing states, Gray along wait-lock-lost
  // ************************************************************
  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_LOCK = 2'h1,
    ST_LOST = 2'h3,
    ST_PRIMARY = 2'h2
  } fst_state_t;

endpackage : fst_pkg

`default_nettype wire

// file: verilog/fst_pulse_if.sv
// Interface between the frame timer and the output pulse generator.
// Assumes both ends run on the same clock.
`default_nettype none

interface fst_pulse_if;
  logic fire;
  fst_pkg::fst_pw_t width_cyc;
  logic level;

  modport ctrl (output fire, output width_cyc, input level);
  modport gen (input fire, input width_cyc, output level);
endinterface : fst_pulse_if

`default_nettype wire

// file: verilog/fst_pulse_gen.sv
// Output trigger pulse generator: a fire strobe starts a pulse of width_cyc cycles.
// Assumes fire is one cycle wide and width_cyc is at least one.
`default_nettype none

module fst_pulse_gen (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Pulse request and level
  fst_pulse_if.gen pif
);

  // ************************************************************
  // Width timer
  // ************************************************************
  fst_pkg::fst_pw_t cnt_q;
  fst_pkg::fst_pw_t cnt_d;
  logic level_q;
  logic level_d;

  // Retrigger restarts the pulse rather than stretching it unpredictably
  always_comb begin
    cnt_d = cnt_q;
    level_d = level_q;
    if (pif.fire) begin
      level_d = 1'b1;
      cnt_d = pif.width_cyc - fst_pkg::fst_pw_t'(1);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - fst_pkg::fst_pw_t'(1);
    end else begin
      level_d = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  assign pif.level = level_q;

endmodule : fst_pulse_gen

`default_nettype wire

// file: verilog/fst_top.sv
// Frame-sync trigger logic: primary emits per-frame trigger pulses,
// secondary takes its frame timing from pulses arriving on its input pin.
// Assumes configuration inputs come from logic on mclk; frame_sync_in is a pin.
//
// Behaviour
// - Primary drives one trigger pulse per frame; period follows the selected rate.
// - Primary pulse width is programmable from 37 ns up to 37 ns plus 25.5 us.
// - Secondary accepts input pulses spaced 8.33 to 66.67 ms as frame timing.
// - Input pin is only ever read, output pin is only ever driven.
`default_nettype none

module fst_top #(
  parameter int unsigned PERIOD_120_CYC = fst_pkg::PERIOD_120_CYC,
  parameter int unsigned PERIOD_30_CYC = fst_pkg::PERIOD_30_CYC,
  parameter int unsigned PERIOD_15_CYC = fst_pkg::PERIOD_15_CYC,
  parameter int unsigned SEC_MIN_CYC = fst_pkg::SEC_MIN_CYC,
  parameter int unsigned SEC_MAX_CYC = fst_pkg::SEC_MAX_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Configuration
  input wire logic primary_mode,
  input wire logic [1:0] rate_sel,
  input wire logic [7:0] sync_pulse_width,
  // Trigger pins
  input wire logic frame_sync_in,
  output logic frame_sync_out,
  // Frame timing status
  output logic frame_start,
  output logic sync_locked,
  output logic sync_lost,
  output logic period_err,
  output logic [fst_pkg::CNT_W-1:0] sync_period
);

  // ************************************************************
  // Counts at counter width
  // ************************************************************
  localparam fst_pkg::fst_cnt_t P120_C = fst_pkg::fst_cnt_t'(PERIOD_120_CYC);
  localparam fst_pkg::fst_cnt_t P30_C = fst_pkg::fst_cnt_t'(PERIOD_30_CYC);
  localparam fst_pkg::fst_cnt_t P15_C = fst_pkg::fst_cnt_t'(PERIOD_15_CYC);
  localparam fst_pkg::fst_cnt_t SMIN_C = fst_pkg::fst_cnt_t'(SEC_MIN_CYC);
  localparam fst_pkg::fst_cnt_t SMAX_C = fst_pkg::fst_cnt_t'(SEC_MAX_CYC);
  localparam fst_pkg::fst_pw_t PW_MIN_C = fst_pkg::fst_pw_t'(fst_pkg::PW_MIN_CYC);
  localparam fst_pkg::fst_pw_t PW_MAX_C = fst_pkg::fst_pw_t'(fst_pkg::PW_MAX_CYC);
  localparam fst_pkg::fst_pw_t PW_STEP_C = fst_pkg::fst_pw_t'(fst_pkg::PW_STEP_CYC);

  // ************************************************************
  // Decoders
  // ************************************************************

  // Frame period for a rate code; the reserved code falls back to 30 fps
  function automatic fst_pkg::fst_cnt_t period_of(input logic [1:0] code);
    fst_pkg::fst_cnt_t p;
    p = P30_C;
    case (fst_pkg::fst_rate_t'(code))
      fst_pkg::RATE_120: p = P120_C;
      fst_pkg::RATE_15: p = P15_C;
      default: p = P30_C;
    endcase
    return p;
  endfunction : period_of

  // Pulse width in cycles, clipped so it never exceeds the longest width
  function automatic fst_pkg::fst_pw_t width_of(input logic [7:0] code);
    fst_pkg::fst_pw_t w;
    w = PW_MIN_C + fst_pkg::fst_pw_t'(code) * PW_STEP_C;
    if (w > PW_MAX_C) begin
      w = PW_MAX_C;
    end
    return w;
  endfunction : width_of

  // ************************************************************
  // Input pin synchroniser and edge detect
  // ************************************************************
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic edge_seen;

  // Stage 0 feeds stage 1 only; stage 2 is the edge reference
  always_comb begin
    sync_d = {sync_q[1:0], frame_sync_in};
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= 3'h0;
    end else if (clk_en) begin
      sync_q <= sync_d;
    end
  end

  // Short 37 ns pulses span at least one sample at 20 ns
  assign edge_seen = sync_q[1] & ~sync_q[2];

  // ************************************************************
  // Pulse generator link
  // ************************************************************
  fst_pulse_if pif ();
  logic fire_c;

  assign pif.fire = fire_c;
  assign pif.width_cyc = width_of(sync_pulse_width);

  fst_pulse_gen u_pulse_gen (
    .mclk (mclk),
    .sys_rst (sys_rst),
    .clk_en (clk_en),
    .pif (pif.gen)
  );

  // ************************************************************
  // Frame timer and mode state
  // ************************************************************
  fst_pkg::fst_state_t state_q;
  fst_pkg::fst_state_t state_d;
  fst_pkg::fst_cnt_t cnt_q;
  fst_pkg::fst_cnt_t cnt_d;
  fst_pkg::fst_cnt_t period_q;
  fst_pkg::fst_cnt_t period_d;
  fst_pkg::fst_cnt_t prd;
  fst_pkg::fst_cnt_t elapsed;
  logic start_q;
  logic start_d;
  logic locked_q;
  logic locked_d;
  logic lost_q;
  logic lost_d;
  logic err_q;
  logic err_d;

  // Mode change wins over frame events so a switch always starts clean
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    period_d = period_q;
    start_d = 1'b0;
    err_d = 1'b0;
    lost_d = lost_q;
    fire_c = 1'b0;
    prd = period_of(rate_sel);
    elapsed = cnt_q + fst_pkg::fst_cnt_t'(1);
    if (primary_mode && (state_q != fst_pkg::ST_PRIMARY)) begin
      // Entering primary fires the first frame at once
      state_d = fst_pkg::ST_PRIMARY;
      cnt_d = fst_pkg::CNT_RESET;
      fire_c = 1'b1;
      start_d = 1'b1;
      period_d = prd;
      lost_d = 1'b0;
    end else if (!primary_mode && (state_q == fst_pkg::ST_PRIMARY)) begin
      // Leaving primary waits for the partner's next edge
      state_d = fst_pkg::ST_WAIT;
      cnt_d = fst_pkg::CNT_RESET;
      lost_d = 1'b0;
    end else begin
      unique case (state_q)
        fst_pkg::ST_PRIMARY: begin
          // Compare with >= so a rate change mid-frame cannot overrun
          if (cnt_q >= prd - fst_pkg::fst_cnt_t'(1)) begin
            cnt_d = fst_pkg::CNT_RESET;
            fire_c = 1'b1;
            start_d = 1'b1;
            period_d = prd;
          end else begin
            cnt_d = elapsed;
          end
        end
        fst_pkg::ST_WAIT, fst_pkg::ST_LOST: begin
          // No reference yet: the first edge is taken as a frame
          if (edge_seen) begin
            state_d = fst_pkg::ST_LOCK;
            cnt_d = fst_pkg::CNT_RESET;
            start_d = 1'b1;
            lost_d = 1'b0;
          end
        end
        fst_pkg::ST_LOCK: begin
          if (edge_seen && (elapsed >= SMIN_C)) begin
            // Spacing inside the window; upper bound held by the timeout
            cnt_d = fst_pkg::CNT_RESET;
            start_d = 1'b1;
            period_d = elapsed;
          end else if (edge_seen) begin
            // Too close to the last frame: ignored, timing unchanged
            err_d = 1'b1;
            cnt_d = elapsed;
          end else if (elapsed >= SMAX_C) begin
            // Partner silent past the longest period
            state_d = fst_pkg::ST_LOST;
            lost_d = 1'b1;
          end else begin
            cnt_d = elapsed;
          end
        end
      endcase
    end
    locked_d = (state_d == fst_pkg::ST_LOCK);
  end

  // Registers only; clk_en low freezes everything
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= fst_pkg::ST_WAIT;
      cnt_q <= fst_pkg::CNT_RESET;
      period_q <= fst_pkg::CNT_RESET;
      start_q <= 1'b0;
      locked_q <= 1'b0;
      lost_q <= 1'b0;
      err_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      period_q <= period_d;
      start_q <= start_d;
      locked_q <= locked_d;
      lost_q <= lost_d;
      err_q <= err_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Output pin is driven in every mode; low while secondary once any pulse begun in primary has ended
  assign frame_sync_out = pif.level;
  assign frame_start = start_q;
  assign sync_locked = locked_q;
  assign sync_lost = lost_q;
  assign period_err = err_q;
  assign sync_period = period_q;

endmodule : fst_top

`default_nettype wire

// file: test/fst_peer.sv
// Peer camera model: sends trigger pulses on request, reads ours.
// Assumes the bench raises go for one mclk cycle per pulse.
`default_nettype none
module fst_peer (
  // Clock, reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Bench request
  input wire logic go,
  // Cross-wired trigger pins
  input wire logic peer_in,
  output logic peer_out,
  output logic [7:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Pulse and edge count
  // ****
  logic [1:0] left_q, left_d;
  logic in_q, in_d;
  logic [7:0] seen_q, seen_d;
  // Two cycles, near the 37 ns typical width
  always_comb begin
    left_d = go ? 2'h2 : (left_q != 2'h0) ? left_q - 2'h1 : 2'h0;
    in_d = peer_in;
    seen_d = (peer_in && !in_q) ? seen_q + 8'h1 : seen_q;
  end
  // Registers only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      left_q <= 2'h0;
      in_q <= 1'b0;
      seen_q <= 8'h0;
    end else begin
      left_q <= left_d;
      in_q <= in_d;
      seen_q <= seen_d;
    end
  end
  // Actively driven low between pulses
  assign peer_out = left_q != 2'h0;
  assign seen = seen_q;
endmodule : fst_peer
`default_nettype wire

// file: test/fst_top_asserts.sv
// Checker for the trigger block, watching top ports only.
// Assumes one mclk domain; bound into every fst_top.
`default_nettype none
module fst_top_chk #(
  parameter int unsigned PERIOD_120_CYC = 40,
  parameter int unsigned PERIOD_30_CYC = 60,
  parameter int unsigned PERIOD_15_CYC = 80,
  parameter int unsigned SEC_MIN_CYC = 30,
  parameter int unsigned SEC_MAX_CYC = 100
) (
  // Clock, reset, config
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic primary_mode,
  input wire logic [1:0] rate_sel,
  input wire logic [7:0] sync_pulse_width,
  // Pins and status
  input wire logic frame_sync_in,
  input wire logic frame_sync_out,
  input wire logic frame_start,
  input wire logic sync_locked,
  input wire logic sync_lost,
  input wire logic period_err,
  input wire logic [fst_pkg::CNT_W-1:0] sync_period
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Reference counters
  // ****
  logic [21:0] gap_q, gap_d, wid_q, wid_d, per;
  logic ok_q, ok_d;
  logic [1:0] rate_q;
  logic [7:0] pw_q;
  logic [10:0] wexp;
  // Config changes void the next check, since wrap point moves
  always_comb begin
    per = (rate_sel == 2'h1) ? 22'(PERIOD_120_CYC) :
      (rate_sel == 2'h2) ? 22'(PERIOD_15_CYC) : 22'(PERIOD_30_CYC);
    // Expected width from the shared step, floor and ceiling
    wexp = 11'(fst_pkg::PW_MIN_CYC) + 11'(sync_pulse_width) * 11'(fst_pkg::PW_STEP_CYC);
    if (wexp > 11'(fst_pkg::PW_MAX_CYC)) wexp = 11'(fst_pkg::PW_MAX_CYC);
    gap_d = gap_q;
    wid_d = wid_q;
    ok_d = ok_q;
    if (clk_en) begin
      gap_d = frame_start ? 22'h1 : gap_q + 22'h1;
      wid_d = frame_sync_out ? wid_q + 22'h1 : 22'h0;
      if (frame_start) ok_d = 1'b1;
    end
    if (!primary_mode || rate_sel != rate_q || sync_pulse_width != pw_q) ok_d = 1'b0;
  end
  // Registers only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_q <= 22'h0;
      wid_q <= 22'h0;
      ok_q <= 1'b0;
      rate_q <= 2'h0;
      pw_q <= 8'h0;
    end else begin
      gap_q <= gap_d;
      wid_q <= wid_d;
      ok_q <= ok_d;
      rate_q <= rate_sel;
      pw_q <= sync_pulse_width;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  frame_period_a: assert property (frame_start && clk_en && ok_q && rate_sel == rate_q |->
    gap_q == per) else $error("frame period wrong");
  pulse_width_a: assert property ($fell(frame_sync_out) && ok_q |-> wid_q == 22'(wexp))
    else $error("pulse width wrong");
  out_start_a: assert property ($rose(frame_sync_out) |-> frame_start)
    else $error("pulse without frame start");
  out_mode_a: assert property ($rose(frame_sync_out) |-> $past(primary_mode))
    else $error("pulse in secondary");
  lock_start_a: assert property ($rose(sync_locked) |-> frame_start && !$past(primary_mode))
    else $error("lock without frame start");
  edge_start_a: assert property ($rose(frame_sync_in) && !sync_locked && !primary_mode
    && clk_en |-> ##[2:5] frame_start) else $error("edge not taken");
  early_edge_a: assert property (period_err |-> !frame_start && $stable(sync_period))
    else $error("early edge used");
  lost_state_a: assert property (sync_lost |-> !sync_locked && !frame_sync_out)
    else $error("lost while locked");
endmodule : fst_top_chk
bind fst_top fst_top_chk #(.PERIOD_120_CYC(PERIOD_120_CYC), .PERIOD_30_CYC(PERIOD_30_CYC),
  .PERIOD_15_CYC(PERIOD_15_CYC), .SEC_MIN_CYC(SEC_MIN_CYC), .SEC_MAX_CYC(SEC_MAX_CYC)) chk (
  .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .primary_mode(primary_mode),
  .rate_sel(rate_sel), .sync_pulse_width(sync_pulse_width), .frame_sync_in(frame_sync_in),
  .frame_sync_out(frame_sync_out), .frame_start(frame_start), .sync_locked(sync_locked),
  .sync_lost(sync_lost), .period_err(period_err), .sync_period(sync_period));
`default_nettype wire

// file: test/frame_sync_trigger_tb.sv
// Bench for the trigger block with a peer camera cross-wired.
// Assumes short period parameters so frames last tens of cycles.
`default_nettype none
module frame_sync_trigger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Setup
  // ****
  localparam int unsigned P120 = 40;
  localparam int unsigned P30 = 60;
  localparam int unsigned P15 = 80;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic primary_mode = 1'b1;
  logic [1:0] rate_sel = 2'h0;
  logic [7:0] sync_pulse_width = 8'h0;
  logic go = 1'b0;
  logic s_in, s_out, f_start, locked, lost, p_err;
  logic [fst_pkg::CNT_W-1:0] s_per;
  logic [7:0] seen;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_go = 0;
  // 50 MHz clock and a cycle count for pulse spacing
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  fst_top #(.PERIOD_120_CYC(P120), .PERIOD_30_CYC(P30), .PERIOD_15_CYC(P15),
    .SEC_MIN_CYC(30), .SEC_MAX_CYC(100)) DUT (.mclk(mclk), .sys_rst(sys_rst),
    .clk_en(clk_en), .primary_mode(primary_mode), .rate_sel(rate_sel),
    .sync_pulse_width(sync_pulse_width), .frame_sync_in(s_in), .frame_sync_out(s_out),
    .frame_start(f_start), .sync_locked(locked), .sync_lost(lost), .period_err(p_err),
    .sync_period(s_per));
  fst_peer peer (.mclk(mclk), .sys_rst(sys_rst), .go(go), .peer_in(s_out),
    .peer_out(s_in), .seen(seen));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  // Counts falling edges up to a sampled frame start, bounded
  task wait_start(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (f_start !== 1'b1 && n < 200);
  endtask : wait_start
  // Peer pulse requested at cycle c
  task fire(input int c);
    // Always launch on a rising edge, even when the cycle is already due
    do begin
      @(posedge mclk);
    end while (cyc < c);
    go <= 1'b1;
    t_go = c;
    @(posedge mclk);
    go <= 1'b0;
  endtask : fire
  task t_primary;
    logic [31:0] per [4];
    int n;
    int w;
    per = '{P30, P120, P15, P30};
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk);
      rate_sel <= 2'(r);
      sync_pulse_width <= 8'(r * 2);
      wait_start(n);
      wait_start(n);
      w = 0;
      while (s_out === 1'b1 && w < 100) begin
        w++;
        @(negedge mclk);
      end
      wait_start(n);
      chk(w, 2 + 10 * r);
      chk(n + w, per[r]);
      chk(s_per, per[r]);
    end
    chk(32'(seen > 8'h4), 1);
  endtask : t_primary
  // Frozen cycles stretch the frame by exactly their number
  task t_freeze;
    int n;
    @(posedge mclk);
    rate_sel <= 2'h0;
    wait_start(n);
    wait_start(n);
    repeat (3) @(posedge mclk);
    clk_en <= 1'b0;
    repeat (10) @(posedge mclk);
    clk_en <= 1'b1;
    wait_start(n);
    chk(n + 12, P30 + 10);
  endtask : t_freeze
  task t_secondary;
    int n;
    logic e;
    logic s;
    @(posedge mclk);
    primary_mode <= 1'b0;
    fire(cyc + 20);
    wait_start(n);
    chk(32'(n < 7), 1);
    chk(locked, 1);
    n = t_go;
    fire(n + 50);
    wait_start(n);
    chk(s_per, 50);
    chk(s_out, 0);
    fire(t_go + 20);
    e = 1'b0;
    s = 1'b0;
    repeat (8) begin
      @(negedge mclk);
      e = e | p_err;
      s = s | f_start;
    end
    chk(e, 1);
    chk(s, 0);
    for (int i = 0; i < 150 && lost !== 1'b1; i++) @(negedge mclk);
    chk({lost, locked}, 2'h2);
    fire(cyc + 5);
    wait_start(n);
    chk({lost, locked}, 2'h1);
    // Back to primary: first frame fires at once, lock state cleared
    @(posedge mclk);
    primary_mode <= 1'b1;
    wait_start(n);
    chk(n, 2);
    chk({s_out, lost, locked}, 3'h4);
    chk(s_per, P30);
  endtask : t_secondary
  task final_report;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Main sequence after four cycles of reset
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t_primary();
    t_freeze();
    t_secondary();
    final_report();
  end
  // Watchdog, well past the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    final_report();
  end
endmodule : frame_sync_trigger_tb
`default_nettype wire
